/* File: include/sys_pins_cfg.svh */
`ifndef SYS_PINS_CFG_SVH
`define SYS_PINS_CFG_SVH

// Core clock period in picoseconds (100 MHz)
`define CORE_CLK_PERIOD_PS   32'd10000
// Slow clock period in picoseconds (32.768 MHz, about 30.5 ns)
`define SLOW_CLK_PERIOD_PS   32'd30518
// Core cycles per slow tick, rounded down
`define SLOW_DIV_COUNT       (`SLOW_CLK_PERIOD_PS / `CORE_CLK_PERIOD_PS)
// Least erase assertion time, in slow clock ticks
`define ERASE_MIN_TICKS      16'd220
// Least width of a reset pulse driven out, in ns
`define RST_OUT_MIN_NS       32'd1000
// Core cycles for that pulse, rounded up
`define RST_OUT_CYCLES       ((`RST_OUT_MIN_NS * 32'd1000 + `CORE_CLK_PERIOD_PS - 32'd1) / `CORE_CLK_PERIOD_PS)
// Width of the slow divider and the reset pulse counter
`define DIV_W                12
`define RST_CNT_W            8
// Reset value of the mode strap latch
`define STRAP_RESET          1'b0

`endif

/* File: include/sys_pins_pkg.sv */
package sys_pins_pkg;

  // Reset pin drive state, one-hot
  typedef enum logic [2:0] {
    RST_IDLE  = 3'b001,
    RST_DRIVE = 3'b010,
    RST_WAIT  = 3'b100
  } rst_state_t;

endpackage : sys_pins_pkg

/* File: rtl/erase_debounce.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sys_pins_cfg.svh"

// ************************************************
// Erase pin debounce on the slow tick
// ************************************************
module erase_debounce
  import sys_pins_pkg::*;
(
  input  wire logic core_clk,   // Core clock
  input  wire logic rst_b,      // Async reset, active low
  input  wire logic slow_tick,  // One-cycle slow clock enable
  input  wire logic pin_level,  // Raw erase level, already gated
  output logic      erase_req   // One-cycle accepted request
);

  logic        sync1;           // First synchroniser stage
  logic        sync2;           // Second synchroniser stage
  logic [15:0] count;           // Ticks the level has stayed high
  logic        done;            // Request already issued for this press
  logic [15:0] next_count;
  logic        next_done;
  logic        next_req;

  // Next count, request and done flags
  always_comb begin
    next_count = count;
    next_done  = done;
    next_req   = 1'b0;
    if (!sync2) begin
      // Level dropped early: start over
      next_count = 16'h0000;
      next_done  = 1'b0;
    end else if (slow_tick && !done) begin
      // Count only on the slow tick
      if (count + 16'h0001 >= `ERASE_MIN_TICKS) begin
        next_req  = 1'b1;
        next_done = 1'b1;
        next_count = count;
      end else begin
        next_count = count + 16'h0001;
      end
    end
  end

  // Register stage
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1     <= 1'b0;
      sync2     <= 1'b0;
      count     <= 16'h0000;
      done      <= 1'b0;
      erase_req <= 1'b0;
    end else begin
      sync1     <= pin_level;
      sync2     <= sync1;
      count     <= next_count;
      done      <= next_done;
      erase_req <= next_req;
    end
  end

  // Request only after the full count of high ticks
  chk_erase_needs_level: assert property (@(posedge core_clk) disable iff (!rst_b)
    erase_req |-> $past(sync2) && $past(count) == `ERASE_MIN_TICKS - 16'h0001)
    else $error("erase request without full debounce");

  // Low level clears the count
  chk_count_clears: assert property (@(posedge core_clk) disable iff (!rst_b)
    !sync2 |=> count == 16'h0000)
    else $error("debounce count not cleared on low level");

endmodule : erase_debounce
`default_nettype wire

/* File: rtl/sys_pins.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sys_pins_cfg.svh"

// Function
// - Strap sampled at power-up: high means test
// - Reset pin bidirectional, driven or pulled low
// - Pin reset spares the backup region
// - Any input pulse accepted; output pulse minimum
// - Reset pin starts as input, drive off
// - Accepted erase sets flash to all ones
// - Erase works even when flash secured
// - Erase debounced on slow clock, minimum time
// - Erase pin dedicated at startup, not general
// - Driving erase pin low never erases
module sys_pins
  import sys_pins_pkg::*;
(
  input  wire logic core_clk,          // Core clock, 100 MHz
  input  wire logic rst_b,             // Power-up reset, active low
  input  wire logic test_mode_strap,   // Mode strap level
  output logic      test_mode,         // Latched mode: 1 test, 0 normal
  input  wire logic ext_reset_pin_in,  // Reset pin level seen
  output logic      ext_reset_pin_out, // Reset pin output value (always 0)
  output logic      ext_reset_pin_oe_b,// Reset pin enable, low drives
  input  wire logic reset_request,     // On-chip cause wants a reset out
  output logic      core_periph_rst_b, // Reset to core and peripherals
  output logic      backup_rst_b,      // Reset to backup region
  input  wire logic erase_pin_in,      // Erase pin level seen
  input  wire logic erase_gpio_sel,    // Pin handed to general I/O
  input  wire logic flash_secure,      // Flash security bit
  output logic      flash_erase_start, // One-cycle erase start
  output logic      flash_fill_ones    // Erase pattern: all bits one
);

  // ************************************************
  // Slow clock enable divider
  // ************************************************
  logic [`DIV_W-1:0] div_cnt;          // Core cycles into slow period
  logic [`DIV_W-1:0] next_div_cnt;
  logic              slow_tick;        // One-cycle slow enable
  logic              next_slow_tick;

  // Wrap the divider once per slow period
  always_comb begin
    next_slow_tick = 1'b0;
    if (div_cnt == `DIV_W'(`SLOW_DIV_COUNT - 1)) begin
      next_div_cnt   = '0;
      next_slow_tick = 1'b1;
    end else begin
      next_div_cnt = div_cnt + `DIV_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt   <= '0;
      slow_tick <= 1'b0;
    end else begin
      div_cnt   <= next_div_cnt;
      slow_tick <= next_slow_tick;
    end
  end

  // ************************************************
  // Mode strap capture
  // ************************************************
  logic strap_taken;                   // Strap already captured
  logic next_strap_taken;
  logic next_test_mode;

  // Capture once on the first edge after reset release; later changes
  // on the pin are ignored since the board must keep it fixed
  always_comb begin
    next_strap_taken = 1'b1;
    next_test_mode   = test_mode;
    if (!strap_taken) begin
      next_test_mode = test_mode_strap;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_taken <= 1'b0;
      test_mode   <= `STRAP_RESET;
    end else begin
      strap_taken <= next_strap_taken;
      test_mode   <= next_test_mode;
    end
  end

  // ************************************************
  // Reset pin: drive out and take in
  // ************************************************
  rst_state_t             rst_state;   // Drive state
  rst_state_t             next_rst_state;
  logic [`RST_CNT_W-1:0]  rst_cnt;     // Cycles driven so far
  logic [`RST_CNT_W-1:0]  next_rst_cnt;
  logic                   pin_q;       // Registered pin level
  logic                   next_oe_b;
  logic [`RST_CNT_W-1:0]  low_run;     // Cycles the pin drive has stayed on
  logic [`RST_CNT_W-1:0]  next_low_run;

  // Drive low for at least the minimum width, then release and
  // wait for the pin to return high before another pulse
  always_comb begin
    next_rst_state = rst_state;
    next_rst_cnt   = rst_cnt;
    next_oe_b      = 1'b1;
    unique case (rst_state)
      RST_IDLE: begin
        if (reset_request) begin
          next_rst_state = RST_DRIVE;
          next_rst_cnt   = '0;
          next_oe_b      = 1'b0;
        end
      end
      RST_DRIVE: begin
        next_oe_b = 1'b0;
        if (rst_cnt >= `RST_CNT_W'(`RST_OUT_CYCLES - 1)) begin
          next_rst_state = RST_WAIT;
          next_oe_b      = 1'b1;
        end else begin
          next_rst_cnt = rst_cnt + `RST_CNT_W'(1);
        end
      end
      RST_WAIT: begin
        // Wait for the pull-up to bring the line back
        if (ext_reset_pin_in) begin
          next_rst_state = RST_IDLE;
        end
      end
      default: begin
        next_rst_state = RST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_state          <= RST_IDLE;
      rst_cnt            <= '0;
      ext_reset_pin_oe_b <= 1'b1;     // Input after reset
      pin_q              <= 1'b1;
    end else begin
      rst_state          <= next_rst_state;
      rst_cnt            <= next_rst_cnt;
      ext_reset_pin_oe_b <= next_oe_b;
      pin_q              <= ext_reset_pin_in;
    end
  end

  // Drive length for the width check; saturates so a stuck drive cannot wrap
  always_comb begin
    next_low_run = low_run;
    if (ext_reset_pin_oe_b) begin
      next_low_run = '0;
    end else if (low_run != '1) begin
      next_low_run = low_run + `RST_CNT_W'(1);
    end
  end

  // Register the drive length
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_run <= '0;
    end else begin
      low_run <= next_low_run;
    end
  end

  // Only ever drives low; open-drain style
  assign ext_reset_pin_out = 1'b0;

  // Any low on the pin, however short, resets core and peripherals;
  // pass-through keeps even a single-cycle pulse
  assign core_periph_rst_b = rst_b & ext_reset_pin_in & pin_q;
  // Backup region sees only the power-up reset
  assign backup_rst_b      = rst_b;

  // ************************************************
  // Erase pin
  // ************************************************
  logic erase_level;                  // Pin level while dedicated
  logic erase_req;                    // Debounced accepted request

  // General I/O use masks the pin, so a low output never erases;
  // security bit does not gate the path
  assign erase_level = erase_pin_in & ~erase_gpio_sel;

  erase_debounce u_erase (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .slow_tick (slow_tick),
    .pin_level (erase_level),
    .erase_req (erase_req)
  );

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flash_erase_start <= 1'b0;
      flash_fill_ones   <= 1'b0;
    end else begin
      flash_erase_start <= erase_req;
      flash_fill_ones   <= erase_req;
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  sequence drive_low_s;
    $fell(ext_reset_pin_oe_b);
  endsequence

  chk_rst_min_width: assert property (@(posedge core_clk) disable iff (!rst_b)
    drive_low_s |-> !ext_reset_pin_oe_b [*8])
    else $error("reset pulse shorter than minimum");

  // The 8-cycle window above cannot see a pulse cut after more than 8 cycles
  chk_rst_full_width: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(ext_reset_pin_oe_b) |-> low_run >= `RST_CNT_W'(`RST_OUT_CYCLES))
    else $error("reset pulse shorter than full count");

  chk_rst_pin_input: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rst_state == RST_IDLE) |-> ext_reset_pin_oe_b)
    else $error("reset pin driven while idle");

  chk_pin_resets_core: assert property (@(posedge core_clk) disable iff (!rst_b)
    !ext_reset_pin_in |-> !core_periph_rst_b && backup_rst_b)
    else $error("pin reset mishandled");

  chk_strap_held: assert property (@(posedge core_clk) disable iff (!rst_b)
    strap_taken |=> $stable(test_mode))
    else $error("mode changed after capture");

  chk_gpio_no_erase: assert property (@(posedge core_clk) disable iff (!rst_b)
    erase_gpio_sel [*4] |=> !erase_req)
    else $error("erase while pin is general I/O");

  chk_erase_fill: assert property (@(posedge core_clk) disable iff (!rst_b)
    erase_req |=> flash_erase_start && flash_fill_ones)
    else $error("erase not started after request");

  chk_secure_erase: assert property (@(posedge core_clk) disable iff (!rst_b)
    (erase_req && flash_secure) |=> flash_erase_start)
    else $error("secured device not erased");

endmodule : sys_pins
`default_nettype wire

/* File: dv/board_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ************************************************
// Board parts around the system pins
// ************************************************
module board_model (
  input  wire logic ext_reset_pin_out,  // Device pin value
  input  wire logic ext_reset_pin_oe_b, // Device drive, low drives
  input  wire logic ext_pull_low,       // Outside source pulls low
  input  wire logic strap_level,        // Mode picked at power-up
  input  wire logic erase_press,        // Erase button held
  output logic      ext_reset_pin_in,   // Resolved reset wire
  output logic      test_mode_strap,    // Strap wire
  output logic      erase_pin_in        // Erase wire
);
  // Open-drain reset wire, pull-up wins when nobody pulls
  assign ext_reset_pin_in = !((!ext_reset_pin_oe_b && !ext_reset_pin_out) || ext_pull_low);
  // Strap only moves while power-up reset is held
  assign test_mode_strap = strap_level;
  // Pull-down keeps erase low at startup unless pressed
  assign erase_pin_in = erase_press;
endmodule : board_model
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sys_pins_cfg.svh"

// ************************************************
// System pin bench
// ************************************************
module tb;
  localparam int ERASE_CYC = `ERASE_MIN_TICKS * `SLOW_DIV_COUNT; // Least press, core cycles
  logic core_clk;          // 100 MHz clock
  logic rst_b;             // Power-up reset
  logic reset_request;     // Internal reset cause
  logic erase_gpio_sel;    // Erase pin given away
  logic flash_secure;      // Security bit
  logic ext_pull_low;      // Outside reset source
  logic strap_level;       // Board strap choice
  logic erase_press;       // Erase button
  logic test_mode_strap;   // Strap wire
  logic test_mode;         // Latched mode
  logic rst_pin;           // Resolved reset wire
  logic rst_out;           // Pin value from device
  logic rst_oe_b;          // Pin drive, low drives
  logic core_periph_rst_b; // Core reset
  logic backup_rst_b;      // Backup reset
  logic erase_pin_in;      // Erase wire
  logic flash_erase_start; // Erase pulse
  logic flash_fill_ones;   // Fill pattern pulse
  int   num_errors = 0;    // Mismatches
  int   compares = 0;      // Comparisons
  int   erase_seen = 0;    // Erase pulses seen
  int   fill_seen = 0;     // Fill pulses seen
  int   cycles = 0;        // Timeout counter

  sys_pins DUT (.core_clk(core_clk), .rst_b(rst_b), .test_mode_strap(test_mode_strap), .test_mode(test_mode),
    .ext_reset_pin_in(rst_pin), .ext_reset_pin_out(rst_out), .ext_reset_pin_oe_b(rst_oe_b),
    .reset_request(reset_request), .core_periph_rst_b(core_periph_rst_b), .backup_rst_b(backup_rst_b),
    .erase_pin_in(erase_pin_in), .erase_gpio_sel(erase_gpio_sel), .flash_secure(flash_secure),
    .flash_erase_start(flash_erase_start), .flash_fill_ones(flash_fill_ones));

  board_model board (.ext_reset_pin_out(rst_out), .ext_reset_pin_oe_b(rst_oe_b), .ext_pull_low(ext_pull_low),
    .strap_level(strap_level), .erase_press(erase_press), .ext_reset_pin_in(rst_pin),
    .test_mode_strap(test_mode_strap), .erase_pin_in(erase_pin_in));

  // Free running clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Pulse counters and hang guard; whole run is near 3500 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (flash_erase_start === 1'b1) erase_seen <= erase_seen + 1;
    if (flash_fill_ones === 1'b1) fill_seen <= fill_seen + 1;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  // Compare and count
  task automatic check(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask : check

  // Hold erase button level for n cycles
  task automatic hold(input logic lvl, input int n);
    @(posedge core_clk);
    erase_press <= lvl;
    repeat (n) @(posedge core_clk);
    #1;
  endtask : hold

  // Power-up reset with a strap level
  task automatic test_reset(input logic strap);
    @(posedge core_clk);
    rst_b       <= 1'b0;
    strap_level <= strap;
    @(posedge core_clk);
    #1;
    check(rst_oe_b, 1'b1, "pin driven in reset");
    check(core_periph_rst_b, 1'b0, "core free in reset");
    @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check(test_mode, strap, "mode strap");
    check(rst_oe_b, 1'b1, "pin not input");
    $display("test reset strap %0b done", strap);
  endtask : test_reset

  // One-cycle pulse from outside
  task automatic test_pin_in;
    @(posedge core_clk);
    ext_pull_low <= 1'b1;
    #1;
    check(core_periph_rst_b, 1'b0, "core not reset");
    check(backup_rst_b, 1'b1, "backup reset");
    @(posedge core_clk);
    ext_pull_low <= 1'b0;
    #1;
    check(core_periph_rst_b, 1'b0, "short pulse lost");
    @(posedge core_clk);
    #1;
    check(core_periph_rst_b, 1'b1, "core stuck");
    $display("test pin in done");
  endtask : test_pin_in

  // Outgoing reset pulse length
  task automatic test_pin_out;
    int n;
    @(posedge core_clk);
    reset_request <= 1'b1;
    @(posedge core_clk);
    reset_request <= 1'b0;
    #1;
    for (n = 0; n < 4 && rst_oe_b !== 1'b0; n++) begin
      @(posedge core_clk);
      #1;
    end
    check(rst_oe_b, 1'b0, "pin drive not on");
    check(rst_out, 1'b0, "pin not driven low");
    check(core_periph_rst_b, 1'b0, "core not reset");
    check(backup_rst_b, 1'b1, "backup reset");
    // A request during the drive must be ignored, so no second pulse follows
    for (n = 0; n < 300 && rst_oe_b === 1'b0; n++) begin
      @(posedge core_clk);
      reset_request <= (n == 10);
      #1;
    end
    check(n == `RST_OUT_CYCLES, 1'b1, "pulse length");
    repeat (3) @(posedge core_clk);
    #1;
    check(rst_oe_b, 1'b1, "drive back");
    check(core_periph_rst_b, 1'b1, "core stuck");
    $display("test pin out done");
  endtask : test_pin_out

  // Short presses, secured full press, held press
  task automatic test_erase;
    int base;
    base = erase_seen;
    hold(1'b1, ERASE_CYC - 60);
    hold(1'b0, 12);
    hold(1'b1, ERASE_CYC - 60);
    hold(1'b0, 12);
    check(erase_seen == base, 1'b1, "early erase");
    @(posedge core_clk);
    flash_secure <= 1'b1;
    hold(1'b1, ERASE_CYC + 60);
    check(erase_seen == base + 1, 1'b1, "no erase");
    check(fill_seen == erase_seen, 1'b1, "fill pattern");
    hold(1'b1, ERASE_CYC + 60);
    hold(1'b0, 12);
    check(erase_seen == base + 1, 1'b1, "repeat erase");
    $display("test erase done");
  endtask : test_erase

  // Pin given to general I/O
  task automatic test_gpio;
    int base;
    base = erase_seen;
    @(posedge core_clk);
    erase_gpio_sel <= 1'b1;
    hold(1'b1, ERASE_CYC + 60);
    hold(1'b0, 12);
    check(erase_seen == base, 1'b1, "io erased");
    @(posedge core_clk);
    erase_gpio_sel <= 1'b0;
    $display("test gpio done");
  endtask : test_gpio

  // Closing report
  task automatic print_verdict;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    rst_b          = 1'b0;
    reset_request  = 1'b0;
    erase_gpio_sel = 1'b0;
    flash_secure   = 1'b0;
    ext_pull_low   = 1'b0;
    strap_level    = 1'b0;
    erase_press    = 1'b0;
    test_reset(1'b0);
    test_pin_in();
    test_pin_out();
    test_erase();
    test_gpio();
    test_reset(1'b1);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
